/* design/psl_loader.sv */
// Purpose: power-up strap capture and default tuning word load
// Assumes: supply monitors and reset pin arrive asynchronously
// Notes: strap pins released while the reset pulse stands
//        captured levels lag the pins by the synchroniser depth
// Functional notes
// (RL1) supplies good start internal 75 ns pulse; code holds the pulse 3 cycles, 300 ns
// (RL2) release status pins during reset
// (RL3) capture four pins at pulse fall
// (RL4) reset pin repeats release and capture
// (RL5) eight-entry 16-bit ROM, low strap bits
// (RL6) ROM word loads active word directly
// (RL7) fourth bit selects clock source
// (RL8) PLL path starts multiplier at 40
// (RL9) ROM entries give listed output frequencies
// (RL10) strap load bypasses update command
// (RL11) captured value fixed until next reset
`timescale 1ns/1ps
`default_nettype none
module psl_loader (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // supply monitors and reset pin
  input wire logic supply33_good,
  input wire logic supply18_good,
  input wire logic reset_pin,
  // status pins
  input wire logic strap_pin_bit0_in,
  input wire logic strap_pin_bit1_in,
  input wire logic strap_pin_bit2_in,
  input wire logic strap_pin_clock_select_in,
  input wire logic [psl_pkg::STRAP_W-1:0] status_out_data,
  output logic [psl_pkg::STRAP_W-1:0] status_pin_out,
  output logic [psl_pkg::STRAP_W-1:0] status_pin_oe_n,
  // configuration results
  output logic reset_active,
  output logic [psl_pkg::FTW_W-1:0] active_tuning_word,
  output logic system_sample_clock_direct,
  output logic [7:0] pll_multiplier
);
  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  // only the second stage of each pair is read
  logic [1:0] sup_sync1_ff;
  logic [1:0] sup_sync2_ff;
  logic rst_pin_sync1_ff;
  logic rst_pin_sync2_ff;
  logic [psl_pkg::STRAP_W-1:0] pins_sync1_ff;
  logic [psl_pkg::STRAP_W-1:0] pins_sync2_ff;
  // supply monitors
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sup_sync1_ff <= 2'h0;
      sup_sync2_ff <= 2'h0;
    end else begin
      sup_sync1_ff <= {supply33_good, supply18_good};
      sup_sync2_ff <= sup_sync1_ff;
    end
  end

  // external reset pin
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rst_pin_sync1_ff <= 1'b0;
      rst_pin_sync2_ff <= 1'b0;
    end else begin
      rst_pin_sync1_ff <= reset_pin;
      rst_pin_sync2_ff <= rst_pin_sync1_ff;
    end
  end

  // status pin levels
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pins_sync1_ff <= 4'h0;
      pins_sync2_ff <= 4'h0;
    end else begin
      pins_sync1_ff <= {strap_pin_clock_select_in, strap_pin_bit2_in, strap_pin_bit1_in,
                        strap_pin_bit0_in};
      pins_sync2_ff <= pins_sync1_ff;
    end
  end
  logic sup_ok;
  logic rst_pin_s;
  logic [psl_pkg::STRAP_W-1:0] pins_s;
  assign sup_ok = &sup_sync2_ff;
  assign rst_pin_s = rst_pin_sync2_ff;
  assign pins_s = pins_sync2_ff;

  // ------------------------------------------------------------
  // reset pulse sequencer
  // ------------------------------------------------------------
  psl_pkg::psl_state_t state_ff;
  logic [7:0] cnt_ff;
  logic pulse_done;
  logic pulse_fall;
  // pulse outlasts the synchroniser so released pin levels are captured
  assign pulse_done = (cnt_ff >= 8'(psl_pkg::PULSE_HOLD_CYC - 1));
  assign pulse_fall = (state_ff == psl_pkg::ST_PULSE) && sup_ok && !rst_pin_s && pulse_done;
  assign reset_active = (state_ff != psl_pkg::ST_RUN);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= psl_pkg::ST_IDLE;
    end else begin
      case (state_ff)
        psl_pkg::ST_IDLE: begin
          if (sup_ok) begin
            state_ff <= psl_pkg::ST_PULSE; // RL1
          end
        end
        psl_pkg::ST_PULSE: begin
          if (!sup_ok) begin
            state_ff <= psl_pkg::ST_IDLE;
          end else if (pulse_fall) begin
            state_ff <= psl_pkg::ST_RUN;
          end
        end
        default: begin
          if (!sup_ok) begin
            state_ff <= psl_pkg::ST_IDLE;
          end else if (rst_pin_s) begin
            state_ff <= psl_pkg::ST_PULSE; // RL4
          end
        end
      endcase
    end
  end

  // held at zero outside the pulse and while the reset pin stands
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_ff <= 8'h00;
    end else if ((state_ff != psl_pkg::ST_PULSE) || rst_pin_s) begin
      cnt_ff <= 8'h00;
    end else if (!pulse_done) begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // status pin drive
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_pin_out <= 4'h0;
    end else begin
      status_pin_out <= status_out_data;
    end
  end

  // ------------------------------------------------------------
  // pin release
  // ------------------------------------------------------------
  // high while released, combinational so release is same cycle
  assign status_pin_oe_n = {psl_pkg::STRAP_W{reset_active}}; // RL2

  // ------------------------------------------------------------
  // strap capture
  // ------------------------------------------------------------
  logic [psl_pkg::STRAP_W-1:0] strap_ff;
  logic load_ff;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strap_ff <= 4'h0;
    end else if (pulse_fall) begin
      strap_ff <= pins_s; // RL3 RL11
    end
  end
  // one-cycle strobe that applies the fresh strap value
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      load_ff <= 1'b0;
    end else begin
      load_ff <= pulse_fall;
    end
  end

  // ------------------------------------------------------------
  // default tuning word load
  // ------------------------------------------------------------
  logic [psl_pkg::FTW_W-1:0] rom_word;
  psl_rom u_rom (
    .sel(strap_ff[psl_pkg::SEL_W-1:0]), // RL5
    .word(rom_word)
  );
  // no update strobe needed, the word goes straight to the active copy
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      active_tuning_word <= psl_pkg::ROM_W0;
    end else if (load_ff) begin
      active_tuning_word <= rom_word; // RL6 RL9 RL10
    end
  end

  // ------------------------------------------------------------
  // clock source select
  // ------------------------------------------------------------
  // multiplier value that goes with a clock source
  function automatic logic [7:0] mult_for_source(input logic direct_sel);
    logic [7:0] mult;
    if (direct_sel == psl_pkg::CLKSRC_PLL) begin
      mult = psl_pkg::PLL_MULT_DEFAULT;
    end else begin
      mult = psl_pkg::PLL_MULT_DIRECT;
    end
    return mult;
  endfunction : mult_for_source
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      system_sample_clock_direct <= psl_pkg::CLKSRC_PLL;
    end else if (load_ff) begin
      system_sample_clock_direct <= strap_ff[psl_pkg::CLKSEL_BIT]; // RL7
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pll_multiplier <= mult_for_source(psl_pkg::CLKSRC_PLL);
    end else if (load_ff) begin
      pll_multiplier <= mult_for_source(strap_ff[psl_pkg::CLKSEL_BIT]); // RL8
    end
  end
endmodule : psl_loader
`default_nettype wire

/* design/psl_pkg.sv */
// Purpose: constants for the power-up strap loader
// Assumes: 10 MHz clk
// Notes: tuning words are 16-bit ROM entries
package psl_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int POR_PULSE_NS = 75;
  // least time rounds up, never below one cycle
  localparam int POR_PULSE_CYC_RAW = (POR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_PULSE_CYC = (POR_PULSE_CYC_RAW < 1) ? 1 : POR_PULSE_CYC_RAW;
  localparam int SYNC_STAGES = 2;
  // pulse spans the pin synchroniser so released levels reach the capture
  localparam int PULSE_HOLD_CYC =
    (POR_PULSE_CYC > SYNC_STAGES) ? POR_PULSE_CYC : SYNC_STAGES + 1;
  localparam int STRAP_W = 4;
  localparam int FTW_W = 16;
  localparam int ROM_DEPTH = 8;
  localparam int SEL_W = 3;
  localparam int CLKSEL_BIT = 3;
  localparam logic [7:0] PLL_MULT_DEFAULT = 8'h28;
  localparam logic [7:0] PLL_MULT_DIRECT = 8'h01;
  localparam logic CLKSRC_PLL = 1'b0;
  localparam logic CLKSRC_DIRECT = 1'b1;
  // words for 0/38.88/51.83/61.43/77.76/92.15/122.88/155.52 MHz at 1 GHz
  localparam logic [FTW_W-1:0] ROM_W0 = 16'h0000;
  localparam logic [FTW_W-1:0] ROM_W1 = 16'h09F4;
  localparam logic [FTW_W-1:0] ROM_W2 = 16'h0D45;
  localparam logic [FTW_W-1:0] ROM_W3 = 16'h0FBA;
  localparam logic [FTW_W-1:0] ROM_W4 = 16'h13E8;
  localparam logic [FTW_W-1:0] ROM_W5 = 16'h1797;
  localparam logic [FTW_W-1:0] ROM_W6 = 16'h1F75;
  localparam logic [FTW_W-1:0] ROM_W7 = 16'h27D0;
  typedef enum {ST_IDLE, ST_PULSE, ST_RUN} psl_state_t;
endpackage : psl_pkg

/* design/psl_rom.sv */
// Purpose: eight-entry tuning word ROM
// Assumes: combinational lookup
// Notes: none
`timescale 1ns/1ps
`default_nettype none
module psl_rom (
  // lookup
  input wire logic [psl_pkg::SEL_W-1:0] sel,
  output logic [psl_pkg::FTW_W-1:0] word
);
  always_comb begin
    case (sel)
      3'h0: word = psl_pkg::ROM_W0;
      3'h1: word = psl_pkg::ROM_W1;
      3'h2: word = psl_pkg::ROM_W2;
      3'h3: word = psl_pkg::ROM_W3;
      3'h4: word = psl_pkg::ROM_W4;
      3'h5: word = psl_pkg::ROM_W5;
      3'h6: word = psl_pkg::ROM_W6;
      default: word = psl_pkg::ROM_W7;
    endcase
  end
endmodule : psl_rom
`default_nettype wire

/* dv/psl_strap_model.sv */
// Purpose: strap resistors on status pins
// Assumes: device drive beats a resistor
// Notes: none
`timescale 1ns/1ps
`default_nettype none
module psl_strap_model (
  // straps and drive
  input wire logic [3:0] strap,
  input wire logic [3:0] drv,
  input wire logic [3:0] oe_n,
  // pins
  output logic [3:0] pin
);
  assign pin = (strap & oe_n) | (drv & ~oe_n);
endmodule : psl_strap_model
`default_nettype wire

/* dv/psl_checker.sv */
// Purpose: port checks of the loader
// Assumes: bound to psl_loader
// Notes: none
`timescale 1ns/1ps
`default_nettype none
module psl_checker (
  // watched ports
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reset_pin,
  input wire logic supply33_good,
  input wire logic supply18_good,
  input wire logic strap_pin_clock_select_in,
  input wire logic [3:0] status_pin_oe_n,
  input wire logic reset_active,
  input wire logic [15:0] active_tuning_word,
  input wire logic system_sample_clock_direct,
  input wire logic [7:0] pll_multiplier
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_pins_released: assert property (
    reset_active |-> &status_pin_oe_n) else $error("pins driven in reset");
  a_pins_driven: assert property (
    !reset_active |-> status_pin_oe_n == 4'h0) else $error("pins not driven");
  a_word_held: assert property (
    !reset_active && !$past(reset_active) && !$past(reset_active, 2)
    |-> $stable(active_tuning_word)) else $error("word moved");
  a_mult_pll: assert property (
    !system_sample_clock_direct |-> pll_multiplier == 8'h28) else $error("mult not 40");
  a_mult_direct: assert property (
    system_sample_clock_direct |-> pll_multiplier == 8'h01) else $error("mult not 1");
  a_pin_restart: assert property (
    reset_pin [*5] |-> reset_active) else $error("no restart");
  a_supply_good: assert property (
    $fell(reset_active) |-> supply33_good && supply18_good) else $error("no supply");
  a_clock_select: assert property (
    $fell(reset_active) |=> system_sample_clock_direct == $past(strap_pin_clock_select_in, 4))
    else $error("bad clock select");
  a_supply_loss: assert property (
    !supply33_good [*4] |-> reset_active && &status_pin_oe_n) else $error("no supply reset");
endmodule : psl_checker
bind psl_loader psl_checker psl_checker_i (.clk(clk), .rst_n(rst_n), .reset_pin(reset_pin),
  .supply33_good(supply33_good), .supply18_good(supply18_good),
  .strap_pin_clock_select_in(strap_pin_clock_select_in), .status_pin_oe_n(status_pin_oe_n),
  .reset_active(reset_active), .active_tuning_word(active_tuning_word),
  .system_sample_clock_direct(system_sample_clock_direct), .pll_multiplier(pll_multiplier));
`default_nettype wire

/* dv/psl_loader_tb_top.sv */
// Purpose: strap loader testbench
// Assumes: 10 MHz clk
// Notes: none
`timescale 1ns/1ps
`default_nettype none
module psl_loader_tb_top;
  logic clk = 1'b0, rst_n = 1'b0, s33 = 1'b0, s18 = 1'b0, reset_pin = 1'b0;
  logic [3:0] strap = 4'h5, sdata = 4'hA;
  wire logic [3:0] pin, pout, oe_n;
  wire logic ract, direct;
  wire logic [15:0] word;
  wire logic [7:0] mult;
  int fail_count = 0, samples_checked = 0;
  // words for the listed output frequencies at a 1 GHz sample clock
  logic [15:0] rom [8] = '{16'h0000, 16'h09F4, 16'h0D45, 16'h0FBA, 16'h13E8, 16'h1797,
    16'h1F75, 16'h27D0};
  psl_strap_model psl_strap_model_i (.strap(strap), .drv(pout), .oe_n(oe_n), .pin(pin));
  psl_loader psl_loader_i (.clk(clk), .rst_n(rst_n), .supply33_good(s33), .supply18_good(s18),
    .reset_pin(reset_pin), .strap_pin_bit0_in(pin[0]), .strap_pin_bit1_in(pin[1]),
    .strap_pin_bit2_in(pin[2]), .strap_pin_clock_select_in(pin[3]), .status_out_data(sdata),
    .status_pin_out(pout), .status_pin_oe_n(oe_n), .reset_active(ract),
    .active_tuning_word(word), .system_sample_clock_direct(direct), .pll_multiplier(mult));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wait_run();
    int n;
    for (n = 0; n < 20 && ract !== 1'b0; n++) @(negedge clk);
    if (n == 20) begin
      fail_count++;
      end_of_test();
    end
    repeat (2) @(negedge clk);
  endtask : wait_run
  task automatic expect_cfg(input logic [3:0] c);
    check(word, rom[c[2:0]]);
    check({15'h0, direct}, {15'h0, c[3]});
    check({8'h0, mult}, c[3] ? 16'h0001 : 16'h0028);
    check({12'h0, oe_n}, 16'h0000);
  endtask : expect_cfg
  task automatic power_up();
    s33 = 1'b1;
    s18 = 1'b1;
    wait_run();
    expect_cfg(4'h5);
  endtask : power_up
  task automatic all_codes();
    for (int c = 0; c < 16; c++) begin
      strap = 4'(c);
      reset_pin = 1'b1;
      repeat (5) @(negedge clk);
      check({12'h0, oe_n}, 16'h000F);
      reset_pin = 1'b0;
      wait_run();
      expect_cfg(4'(c));
    end
  endtask : all_codes
  task automatic hold_strap();
    strap = 4'h0;
    sdata = 4'h3;
    repeat (3) @(negedge clk);
    expect_cfg(4'hF);
    check({12'h0, pout}, {12'h0, sdata});
  endtask : hold_strap
  task automatic short_pulse();
    strap = 4'h9;
    reset_pin = 1'b1;
    @(negedge clk);
    reset_pin = 1'b0;
    repeat (3) @(negedge clk);
    check({12'h0, oe_n}, 16'h000F);
    wait_run();
    expect_cfg(4'h9);
  endtask : short_pulse
  task automatic supply_drop();
    s33 = 1'b0;
    repeat (4) @(negedge clk);
    check({15'h0, ract}, 16'h0001);
    check({12'h0, oe_n}, 16'h000F);
    strap = 4'h6;
    s33 = 1'b1;
    wait_run();
    expect_cfg(4'h6);
  endtask : supply_drop
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    power_up();
    all_codes();
    hold_strap();
    short_pulse();
    supply_drop();
    end_of_test();
  end
endmodule : psl_loader_tb_top
`default_nettype wire
